// ===== prog_port_pkg.sv
// Constants for the serial instruction execute programming port.
// Assumes a single 250 MHz core clock that oversamples the programmer pins.
package prog_port_pkg;

   // Core clock period and key, command and word sizes
   localparam int CLOCK_PERIOD_NS = 4;
   localparam int KEY_BITS = 32;
   localparam int CMD_BITS = 4;
   localparam int INSTR_BITS = 24;
   localparam int EXEC_CLOCKS = 4;
   localparam int STARTUP_CLOCKS = 9;
   localparam int COUNT_BITS = 6;

   // Counts of serial clocks per phase, at counter width
   localparam logic [5:0] KEY_COUNT = 6'h20;
   localparam logic [5:0] LOAD_COUNT = 6'h18;
   localparam logic [5:0] EXEC_COUNT = 6'h04;
   localparam logic [5:0] CMD_COUNT = 6'h04;
   localparam logic [5:0] STARTUP_COUNT = 6'h09;

   // Codes and values after reset
   localparam logic [31:0] ENTRY_KEY = 32'h4d434851;
   localparam logic [3:0] EXECUTE_CODE = 4'h0;
   localparam logic [23:0] NOP_WORD = 24'h000000;
   localparam logic [31:0] KEY_RESET = 32'h00000000;
   localparam logic [3:0] CMD_RESET = 4'h0;
   localparam logic [23:0] INSTR_RESET = 24'h000000;

   // Port sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      ST_KEY = 3'b000,
      ST_START = 3'b001,
      ST_LOAD = 3'b011,
      ST_EXEC = 3'b010,
      ST_CMD = 3'b110
   } port_state_t;

endpackage : prog_port_pkg

// ===== pin_sync.sv
// Three-stage synchroniser with agreement filter and rising-edge pulse.
// Assumes inputs are asynchronous pins; outputs are on the core clock.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 5
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Raw pins
   input wire logic [WIDTH-1:0] pin,
   // Filtered level and rise pulse
   output logic [WIDTH-1:0] level,
   output logic [WIDTH-1:0] rise
);

   typedef struct packed {
      logic [WIDTH-1:0] ff1;
      logic [WIDTH-1:0] ff2;
      logic [WIDTH-1:0] ff3;
      logic [WIDTH-1:0] level;
      logic [WIDTH-1:0] rise;
   } sync_t;

   sync_t sync_r;
   sync_t sync_nxt;

   // Level follows only when second and third stages agree
   always_comb begin
      sync_nxt = sync_r;
      sync_nxt.ff1 = pin;
      sync_nxt.ff2 = sync_r.ff1;
      sync_nxt.ff3 = sync_r.ff2;
      for (int i = 0; i < WIDTH; i++) begin
         if (sync_r.ff2[i] == sync_r.ff3[i]) begin
            sync_nxt.level[i] = sync_r.ff3[i];
         end
      end
      sync_nxt.rise = sync_nxt.level & ~sync_r.level;
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         sync_r <= '0;
      end else begin
         sync_r <= sync_nxt;
      end
   end

   assign level = sync_r.level;
   assign rise = sync_r.rise;

endmodule : pin_sync

// ===== prog_port.sv
// Device side of the two-wire serial instruction execute programming port.
// Assumes programmer pins are asynchronous; the CPU takes instr_word on
// instr_strobe and stays halted while cpu_suspend is high.
`timescale 1ns/1ps
// Operation
// - CPU held suspended during 24 instruction clocks
// - Instruction executes over the next four clocks
// - Next 4-bit command shifts in during execution
// - First code after reset forced execute, NOP
// - Start-up command spans nine serial clocks
// - After start-up, next 24 clocks load word
// - Serial clock is input only
// - Data pin driven only on own turn
// - Secondary pin pair works like primary pair
// - Commands and data shift LSB first
// - Only the 32-bit key enters program mode
module prog_port
   import prog_port_pkg::*;
(
   // Core clock and reset
   input wire logic clock,
   input wire logic rst,
   // Programming enable pin
   input wire logic master_clear_prog_enable,
   // Primary pin pair
   input wire logic primary_prog_clock,
   input wire logic primary_prog_data_in,
   output logic primary_prog_data_out,
   output logic primary_prog_data_oe,
   // Secondary pin pair
   input wire logic secondary_prog_clock,
   input wire logic secondary_prog_data_in,
   output logic secondary_prog_data_out,
   output logic secondary_prog_data_oe,
   // CPU side
   output logic prog_mode,
   output logic cpu_suspend,
   output logic exec_active,
   output logic forced_nop,
   output logic instr_strobe,
   output logic [23:0] instr_word
);

   typedef struct packed {
      port_state_t st;
      logic [COUNT_BITS-1:0] cnt;
      logic [KEY_BITS-1:0] key;
      logic [CMD_BITS-1:0] cmd;
      logic [INSTR_BITS-1:0] instr;
      logic pair_sel;
      logic pair_locked;
      logic prog_mode;
      logic suspend;
      logic exec;
      logic forced_nop;
      logic strobe;
      logic [INSTR_BITS-1:0] word;
   } port_t;

   port_t r;
   port_t nxt;
   logic [4:0] pin_level;
   logic [4:0] pin_rise;
   logic sel_rise;
   logic sel_data;
   logic master_clear_prog_enable_level;

   // Pins: 0 master_clear_prog_enable, 1 primary clock, 2 primary data, 3 secondary clock, 4 secondary data
   pin_sync #(
      .WIDTH(5)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .pin({secondary_prog_data_in, secondary_prog_clock, primary_prog_data_in,
            primary_prog_clock, master_clear_prog_enable}),
      .level(pin_level),
      .rise(pin_rise)
   );

   // Selected pair: whichever clock moved first after entering the key phase
   always_comb begin
      master_clear_prog_enable_level = pin_level[0];
      sel_rise = r.pair_sel ? pin_rise[3] : pin_rise[1];
      sel_data = r.pair_sel ? pin_level[4] : pin_level[2];
      if (!r.pair_locked) begin
         sel_rise = pin_rise[1] | pin_rise[3];
         sel_data = pin_rise[1] ? pin_level[2] : pin_level[4];
      end
   end

   // Sequencer: steps happen on a rising serial clock edge, except start-up entry and the drop to key phase, which follow the enable level
   always_comb begin
      nxt = r;
      nxt.strobe = 1'b0;
      if (!r.pair_locked && (pin_rise[1] | pin_rise[3])) begin
         nxt.pair_locked = 1'b1;
         nxt.pair_sel = ~pin_rise[1];
      end
      if (r.st != ST_KEY && !master_clear_prog_enable_level) begin
         // Programming enable dropped: back to key phase
         nxt.st = ST_KEY;
         nxt.cnt = '0;
         nxt.key = KEY_RESET;
         nxt.prog_mode = 1'b0;
         nxt.suspend = 1'b0;
         nxt.exec = 1'b0;
         nxt.forced_nop = 1'b0;
         nxt.pair_locked = 1'b0;
      end else begin
         unique case (r.st)
            ST_KEY: begin
               if (sel_rise) begin
                  nxt.key = {r.key[KEY_BITS-2:0], sel_data};
                  if (r.cnt != KEY_COUNT) begin
                     nxt.cnt = r.cnt + 6'h01;
                  end
               end
               if (nxt.cnt == KEY_COUNT && nxt.key == ENTRY_KEY) begin
                  nxt.prog_mode = 1'b1;
               end
               if (r.prog_mode && master_clear_prog_enable_level) begin
                  // Forced execute with a NOP word
                  nxt.st = ST_START;
                  nxt.cnt = '0;
                  nxt.forced_nop = 1'b1;
                  nxt.word = NOP_WORD;
               end
            end
            ST_START: begin
               if (sel_rise) begin
                  nxt.cnt = r.cnt + 6'h01;
                  if (r.cnt == STARTUP_COUNT - 6'h01) begin
                     nxt.st = ST_LOAD;
                     nxt.cnt = '0;
                     nxt.forced_nop = 1'b0;
                     nxt.suspend = 1'b1;
                  end
               end
            end
            ST_LOAD: begin
               if (sel_rise) begin
                  nxt.instr = {sel_data, r.instr[INSTR_BITS-1:1]};
                  nxt.cnt = r.cnt + 6'h01;
                  if (r.cnt == LOAD_COUNT - 6'h01) begin
                     nxt.st = ST_EXEC;
                     nxt.cnt = '0;
                     nxt.suspend = 1'b0;
                     nxt.exec = 1'b1;
                     nxt.word = nxt.instr;
                     nxt.strobe = 1'b1;
                  end
               end
            end
            ST_EXEC, ST_CMD: begin
               if (sel_rise) begin
                  nxt.cmd = {sel_data, r.cmd[CMD_BITS-1:1]};
                  nxt.cnt = r.cnt + 6'h01;
                  if (r.cnt == EXEC_COUNT - 6'h01) begin
                     nxt.cnt = '0;
                     nxt.exec = 1'b0;
                     if (nxt.cmd == EXECUTE_CODE) begin
                        nxt.st = ST_LOAD;
                        nxt.suspend = 1'b1;
                     end else begin
                        nxt.st = ST_CMD;
                     end
                  end
               end
            end
            default: begin
               nxt.st = ST_KEY;
               nxt.cnt = '0;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (rst) begin
         r.st <= ST_KEY;
         r.cnt <= '0;
         r.key <= KEY_RESET;
         r.cmd <= CMD_RESET;
         r.instr <= INSTR_RESET;
         r.pair_sel <= 1'b0;
         r.pair_locked <= 1'b0;
         r.prog_mode <= 1'b0;
         r.suspend <= 1'b0;
         r.exec <= 1'b0;
         r.forced_nop <= 1'b0;
         r.strobe <= 1'b0;
         r.word <= NOP_WORD;
      end else begin
         r <= nxt;
      end
   end

   // Outputs; the port only receives, so data pins are never driven
   assign primary_prog_data_out = 1'b0;
   assign primary_prog_data_oe = 1'b0;
   assign secondary_prog_data_out = 1'b0;
   assign secondary_prog_data_oe = 1'b0;
   assign prog_mode = r.prog_mode;
   assign cpu_suspend = r.suspend;
   assign exec_active = r.exec;
   assign forced_nop = r.forced_nop;
   assign instr_strobe = r.strobe;
   assign instr_word = r.word;

   // Checks
   a_load_suspends: assert property (@(posedge clock) disable iff (rst)
      r.st == ST_LOAD |-> r.suspend)
      else $error("CPU not suspended while loading");
   a_load_count: assert property (@(posedge clock) disable iff (rst)
      r.st == ST_LOAD |-> r.cnt < LOAD_COUNT)
      else $error("Load phase exceeded 24 clocks");
   a_strobe_exec: assert property (@(posedge clock) disable iff (rst)
      $rose(r.exec) |-> r.strobe && !r.suspend && r.cnt == 6'h00)
      else $error("Execution started without hand-over");
   a_exec_window: assert property (@(posedge clock) disable iff (rst)
      r.st == ST_EXEC |-> r.exec && r.cnt < EXEC_COUNT)
      else $error("Execute window wrong length");
   a_start_nop: assert property (@(posedge clock) disable iff (rst)
      r.st == ST_START |-> r.forced_nop && r.word == NOP_WORD)
      else $error("Start-up without forced NOP");
   a_start_length: assert property (@(posedge clock) disable iff (rst)
      $fell(r.forced_nop) && master_clear_prog_enable_level |-> r.st == ST_LOAD && $past(r.cnt) == 6'h08)
      else $error("Start-up did not last nine clocks");
   a_key_gate: assert property (@(posedge clock) disable iff (rst)
      $rose(r.prog_mode) |-> r.key == ENTRY_KEY && r.cnt == KEY_COUNT)
      else $error("Program mode without valid key");
   a_strobe_pulse: assert property (@(posedge clock) disable iff (rst)
      r.strobe |=> !r.strobe)
      else $error("Hand-over strobe longer than one cycle");
   a_pins_quiet: assert property (@(posedge clock) disable iff (rst)
      !primary_prog_data_oe && !secondary_prog_data_oe)
      else $error("Data pin driven out of turn");

endmodule : prog_port

// ===== prog_model.sv
// Programmer model: serial clock and data on one of two pin pairs.
// Assumes one task runs at a time; the clock rests low between frames.
`timescale 1ns/1ps
module prog_model (
   // Pair choice
   input wire logic use_secondary,
   // Primary pair
   output logic primary_clock,
   output logic primary_data,
   // Secondary pair
   output logic secondary_clock,
   output logic secondary_data
);
   logic clk_v;
   logic dat_v;
   // Only the chosen pair toggles, the other rests low
   assign primary_clock = use_secondary ? 1'b0 : clk_v;
   assign secondary_clock = use_secondary ? clk_v : 1'b0;
   assign primary_data = use_secondary ? 1'b0 : dat_v;
   assign secondary_data = use_secondary ? dat_v : 1'b0;
   initial begin
      clk_v = 1'b0;
      dat_v = 1'b0;
   end
   // One bit: data set while clock low, taken at the rise, spoiled after the fall
   task automatic send_bit(input logic b);
      dat_v = b;
      #40;
      clk_v = 1'b1;
      #80;
      clk_v = 1'b0;
      #20;
      dat_v = ~b;
      #20;
   endtask : send_bit
   // Entry key, top bit first
   task automatic send_key(input logic [31:0] k);
      for (int i = 31; i >= 0; i--) send_bit(k[i]);
   endtask : send_key
endmodule : prog_model

// ===== test_serial_instruction_exec_port.sv
// Bench for the programming port: programmer model on the pins, checks at CPU side.
// Assumes a 4 ns core clock and a 160 ns serial clock.
`timescale 1ns/1ps
module test_serial_instruction_exec_port;
   import prog_port_pkg::*;
   logic clock, rst, enable, use_secondary;
   logic m_clk1, m_dat1, m_clk2, m_dat2, d1, d2, out1, oe1, out2, oe2;
   logic prog_mode, cpu_suspend, exec_active, forced_nop, instr_strobe;
   logic [23:0] instr_word;
   int fail_count = 0;
   int cmp_count = 0;
   int strobe_count = 0;
   // Wire level from the port's enable; the model drives otherwise
   assign d1 = oe1 ? out1 : m_dat1;
   assign d2 = oe2 ? out2 : m_dat2;
   prog_model u_prog (.use_secondary(use_secondary), .primary_clock(m_clk1),
      .primary_data(m_dat1), .secondary_clock(m_clk2), .secondary_data(m_dat2));
   prog_port u_dut (.clock(clock), .rst(rst), .master_clear_prog_enable(enable),
      .primary_prog_clock(m_clk1), .primary_prog_data_in(d1),
      .primary_prog_data_out(out1), .primary_prog_data_oe(oe1),
      .secondary_prog_clock(m_clk2), .secondary_prog_data_in(d2),
      .secondary_prog_data_out(out2), .secondary_prog_data_oe(oe2),
      .prog_mode(prog_mode), .cpu_suspend(cpu_suspend), .exec_active(exec_active),
      .forced_nop(forced_nop), .instr_strobe(instr_strobe), .instr_word(instr_word));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   // Count word hand-overs
   always @(posedge clock) if (instr_strobe === 1'b1) strobe_count <= strobe_count + 1;
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Enable pin moves after an edge, then sync latency passes
   task automatic set_enable(input logic v);
      @(posedge clock);
      #1 enable = v;
      repeat (10) @(posedge clock);
      #1;
   endtask : set_enable
   // Four command bits, low bit first; running says an instruction executes meanwhile
   task automatic cmd4(input logic [3:0] c, input logic running);
      for (int i = 0; i < 3; i++) u_prog.send_bit(c[i]);
      check("exec mid cmd", exec_active, running);
      u_prog.send_bit(c[3]);
      check("exec after cmd", exec_active, 0);
      check("suspend after cmd", cpu_suspend, c == 4'h0);
   endtask : cmd4
   // Word then command, checking suspension, hand-over and execution
   task automatic run_word(input logic [23:0] w, input logic [3:0] c);
      int n;
      n = strobe_count;
      for (int i = 0; i < 23; i++) u_prog.send_bit(w[i]);
      check("suspend in load", cpu_suspend, 1);
      check("no early word", 24'(strobe_count), 24'(n));
      u_prog.send_bit(w[23]);
      check("one hand-over", 24'(strobe_count), 24'(n + 1));
      check("word", instr_word, w);
      check("suspend released", cpu_suspend, 0);
      check("exec started", exec_active, 1);
      check("data not driven", {oe1, oe2, out1, out2}, 0);
      cmd4(c, 1'b1);
   endtask : run_word
   // Key, enable, forced start-up with non-zero content
   task automatic start_session(input logic sec);
      use_secondary = sec;
      u_prog.send_key(ENTRY_KEY);
      check("mode", prog_mode, 1);
      set_enable(1'b1);
      check("forced nop", forced_nop, 1);
      for (int i = 0; i < 8; i++) u_prog.send_bit(1'b1);
      check("startup still", forced_nop, 1);
      check("no suspend yet", cpu_suspend, 0);
      u_prog.send_bit(1'b1);
      check("startup over", forced_nop, 0);
      check("load begins", cpu_suspend, 1);
   endtask : start_session
   task automatic test_reset();
      check("mode rst", prog_mode, 0);
      check("outs rst", {cpu_suspend, exec_active, forced_nop, instr_strobe}, 0);
      check("word rst", instr_word, 24'h000000);
      $display("test reset done");
   endtask : test_reset
   // Primary pair, refused command code in the middle
   task automatic test_primary();
      start_session(1'b0);
      run_word(NOP_WORD, 4'h0);
      run_word(24'ha5c31e, 4'h5);
      cmd4(4'h0, 1'b0);
      run_word(24'h5a3ce1, 4'h0);
      $display("test primary done");
   endtask : test_primary
   // Enable drop returns to key phase, word kept
   task automatic test_drop();
      set_enable(1'b0);
      check("mode dropped", prog_mode, 0);
      check("suspend dropped", cpu_suspend, 0);
      check("word kept", instr_word, 24'h5a3ce1);
      $display("test drop done");
   endtask : test_drop
   // Bad key refused, then secondary pair session
   task automatic test_secondary();
      use_secondary = 1'b1;
      u_prog.send_key(ENTRY_KEY ^ 32'h00000100);
      check("bad key", prog_mode, 0);
      start_session(1'b1);
      run_word(NOP_WORD, 4'h0);
      run_word(24'h3c0ff3, 4'h0);
      run_word(NOP_WORD, 4'h0);
      $display("test secondary done");
   endtask : test_secondary
   initial begin
      rst = 1'b1;
      enable = 1'b0;
      use_secondary = 1'b0;
      repeat (5) @(posedge clock);
      #1 rst = 1'b0;
      repeat (10) @(posedge clock);
      #1;
      test_reset();
      test_primary();
      test_drop();
      test_secondary();
      summarize();
   end
   // About 300 serial bits expected; allow three times that
   initial begin
      #150000;
      fail_count++;
      summarize();
   end
endmodule : test_serial_instruction_exec_port
